// ==== rtl/ahl_pkg.sv ====
package ahl_pkg;
  // ****************************************
  // Timing
  // ****************************************
  localparam longint unsigned CLOCK_HZ = 250_000_000;
  localparam longint unsigned HOLD_LIMIT_S = 5;
  localparam longint unsigned HOLD_LEARN_S = 10;
  // Whole seconds at an integer rate, so no rounding is needed
  localparam longint unsigned HOLD_LIMIT_CYC = HOLD_LIMIT_S * CLOCK_HZ;
  localparam longint unsigned HOLD_LEARN_CYC = HOLD_LEARN_S * CLOCK_HZ;

  // ****************************************
  // Register offsets (byte addresses)
  // ****************************************
  localparam logic [5:0] OFS_CTRL = 6'h00;
  localparam logic [5:0] OFS_STATUS = 6'h04;
  localparam logic [5:0] OFS_POSITION = 6'h08;
  localparam logic [5:0] OFS_STROKE = 6'h0C;
  localparam logic [5:0] OFS_LIMIT_IN = 6'h10;
  localparam logic [5:0] OFS_LIMIT_OUT = 6'h14;
  localparam logic [5:0] OFS_LEARN_SPEED = 6'h18;
  localparam logic [5:0] OFS_RUN_SPEED = 6'h1C;
  localparam logic [5:0] OFS_RANGE_SCALE = 6'h20;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CTRL_HOME_BIT = 0;
  localparam int CTRL_LEARN_BIT = 1;
  localparam int CTRL_HOME_EXT_BIT = 2;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_HOMED_BIT = 1;
  localparam int STAT_LEARNED_BIT = 2;
  localparam int STAT_ARMED_BIT = 3;
  localparam int STAT_LEARN_MODE_BIT = 4;
  localparam int STAT_STATE_LSB = 8;

  // ****************************************
  // Reset values and fixed figures
  // ****************************************
  localparam logic [15:0] SAFE_ZONE_STEPS = 16'h0032;
  localparam logic [15:0] HOME_POSITION = 16'h0000;
  localparam logic [15:0] LIMIT_IN_RST = 16'h0000;
  localparam logic [15:0] LIMIT_OUT_RST = 16'hFFFF;
  localparam logic [15:0] STROKE_RST = 16'h0000;
  localparam logic [15:0] RANGE_SCALE_RST = 16'h0400;
  localparam logic [7:0] LEARN_SPEED_RST = 8'h40;
  localparam logic [7:0] RUN_SPEED_RST = 8'hFF;
  localparam logic HOME_EXT_RST = 1'b0;

  typedef enum logic [3:0] {
    AHL_IDLE = 4'h1,
    AHL_SEEK_HOME = 4'h2,
    AHL_SEEK_FAR = 4'h4,
    AHL_RETURN = 4'h8
  } ahl_state_e;
endpackage

// ==== rtl/ahl_hold_timer.sv ====
`timescale 1ns/1ps
module ahl_hold_timer #(
  parameter logic [31:0] SHORT_CYC = 32'h0000_0010,
  parameter logic [31:0] LONG_CYC = 32'h0000_0020
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic hold,
  output logic short_done,
  output logic long_done
);
  logic [31:0] count;

  // Saturates so a very long hold never wraps back below the thresholds
  always_ff @(posedge clock) begin
    if (rst || !hold) begin
      count <= 32'h0000_0000;
    end else if (count != 32'hFFFF_FFFF) begin
      count <= count + 32'h0000_0001;
    end
  end

  always_ff @(posedge clock) begin
    if (rst || !hold) begin
      short_done <= 1'b0;
      long_done <= 1'b0;
    end else begin
      short_done <= (count >= SHORT_CYC);
      long_done <= (count > LONG_CYC);
    end
  end
endmodule // ahl_hold_timer

// ==== rtl/ahl_sequencer.sv ====
// Our own choices: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module ahl_sequencer #(
  parameter logic [31:0] HOLD_LIMIT_CYC = 32'(ahl_pkg::HOLD_LIMIT_CYC),
  parameter logic [31:0] HOLD_LEARN_CYC = 32'(ahl_pkg::HOLD_LEARN_CYC)
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic dir_in_n,
  input wire logic dir_out_n,
  input wire logic pulse_pin,
  input wire logic end_hit,
  input wire logic [5:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic motor_extend,
  output logic motor_retract,
  output logic [7:0] motor_speed,
  output logic [15:0] sync_position,
  output logic busy
);
  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic in_s1, in_s2, out_s1, out_s2, pul_s1, pul_s2, pul_s3;
  logic in_act_d, out_act_d, end_hit_d;

  always_ff @(posedge clock) begin
    if (rst) begin
      in_s1 <= 1'b1;
      in_s2 <= 1'b1;
      out_s1 <= 1'b1;
      out_s2 <= 1'b1;
      pul_s1 <= 1'b0;
      pul_s2 <= 1'b0;
      pul_s3 <= 1'b0;
      in_act_d <= 1'b0;
      out_act_d <= 1'b0;
      end_hit_d <= 1'b0;
    end else begin
      in_s1 <= dir_in_n;
      in_s2 <= in_s1;
      out_s1 <= dir_out_n;
      out_s2 <= out_s1;
      pul_s1 <= pulse_pin;
      pul_s2 <= pul_s1;
      pul_s3 <= pul_s2;
      in_act_d <= ~in_s2;
      out_act_d <= ~out_s2;
      end_hit_d <= end_hit;
    end
  end

  logic in_act, out_act, both_held, in_only, out_only;
  logic pulse_edge, end_edge;
  assign in_act = ~in_s2;
  assign out_act = ~out_s2;
  assign both_held = in_act & out_act;
  assign in_only = in_act & ~out_act;
  assign out_only = out_act & ~in_act;
  assign pulse_edge = pul_s2 & ~pul_s3;
  // Stall stays high while pushing; only its rise ends a phase
  assign end_edge = end_hit & ~end_hit_d;

  // ****************************************
  // Declarations
  // ****************************************
  ahl_pkg::ahl_state_e state;
  logic learn_mode, homed, learned, armed, home_ext;
  logic [15:0] position, stroke, limit_in, limit_out, range_scale;
  logic [7:0] learn_speed, run_speed;
  logic short_done, long_done, short_d, long_d;
  logic bus_wr, start_home, start_learn, sw_home, sw_learn;
  logic cap_out, cap_in, learn_go, short_rise;
  logic next_extend, next_retract;
  logic [7:0] next_speed;
  logic [31:0] rd_value;
  logic idle, at_home_end, at_far_end, up_ext;
  logic ext_blocked, ret_blocked;
  logic last_up, pulse_up;

  assign idle = (state == ahl_pkg::AHL_IDLE);
  assign at_home_end = end_edge && (state == ahl_pkg::AHL_SEEK_HOME ||
                                    state == ahl_pkg::AHL_RETURN);
  assign at_far_end = end_edge && (state == ahl_pkg::AHL_SEEK_FAR);

  // ****************************************
  // Button hold sequences
  // ****************************************
  ahl_hold_timer #(
    .SHORT_CYC(HOLD_LIMIT_CYC),
    .LONG_CYC(HOLD_LEARN_CYC)
  ) u_hold (
    .clock(clock),
    .rst(rst),
    .hold(both_held && idle),
    .short_done(short_done),
    .long_done(long_done)
  );

  always_ff @(posedge clock) begin
    if (rst) begin
      short_d <= 1'b0;
      long_d <= 1'b0;
    end else begin
      short_d <= short_done;
      long_d <= long_done;
    end
  end

  assign short_rise = short_done & ~short_d;
  assign learn_go = long_done & ~long_d;
  assign cap_out = armed && idle && out_only && !out_act_d;
  assign cap_in = armed && idle && in_only && !in_act_d;

  // Arming wins over a clear in the same cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      armed <= 1'b0;
    end else if (short_rise) begin
      armed <= 1'b1;
    end else if (cap_out || cap_in || start_learn) begin
      armed <= 1'b0;
    end
  end

  // ****************************************
  // Sequencer
  // ****************************************
  assign bus_wr = write && !waitrequest;
  assign sw_home = bus_wr && address == ahl_pkg::OFS_CTRL &&
                   writedata[ahl_pkg::CTRL_HOME_BIT];
  assign sw_learn = bus_wr && address == ahl_pkg::OFS_CTRL &&
                    writedata[ahl_pkg::CTRL_LEARN_BIT];
  assign start_learn = learn_go || sw_learn;
  assign start_home = sw_home;

  always_ff @(posedge clock) begin
    if (rst) begin
      state <= ahl_pkg::AHL_IDLE;
      learn_mode <= 1'b0;
    end else begin
      case (state)
        ahl_pkg::AHL_IDLE: begin
          if (start_learn) begin
            state <= ahl_pkg::AHL_SEEK_HOME;
            learn_mode <= 1'b1;
          end else if (start_home) begin
            state <= ahl_pkg::AHL_SEEK_HOME;
            learn_mode <= 1'b0;
          end
        end
        ahl_pkg::AHL_SEEK_HOME: begin
          if (end_edge) begin
            state <= learn_mode ? ahl_pkg::AHL_SEEK_FAR : ahl_pkg::AHL_IDLE;
          end
        end
        ahl_pkg::AHL_SEEK_FAR: begin
          if (end_edge) begin
            state <= ahl_pkg::AHL_RETURN;
          end
        end
        ahl_pkg::AHL_RETURN: begin
          if (end_edge) begin
            state <= ahl_pkg::AHL_IDLE;
            learn_mode <= 1'b0;
          end
        end
        default: begin
          state <= ahl_pkg::AHL_IDLE;
          learn_mode <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      homed <= 1'b0;
      learned <= 1'b0;
    end else begin
      if (at_home_end) begin
        homed <= 1'b1;
      end
      if (at_far_end) begin
        learned <= 1'b1;
      end
    end
  end

  // ****************************************
  // Position counting
  // ****************************************
  // Counts up while moving away from whichever end is home
  always_ff @(posedge clock) begin
    if (rst) begin
      position <= ahl_pkg::HOME_POSITION;
    end else if (at_home_end) begin
      position <= ahl_pkg::HOME_POSITION;
    end else if (pulse_edge && pulse_up) begin
      position <= position + 16'h0001;
    end else if (pulse_edge) begin
      position <= position - 16'h0001;
    end
  end

  // A pulse seen after the drive stops is coast; count it the last way
  always_ff @(posedge clock) begin
    if (rst) begin
      last_up <= 1'b0;
    end else if (motor_extend || motor_retract) begin
      last_up <= home_ext ? motor_retract : motor_extend;
    end
  end

  assign pulse_up = (motor_extend || motor_retract) ?
                    (home_ext ? motor_retract : motor_extend) : last_up;

  // ****************************************
  // Learned travel data
  // ****************************************
  // Hardware updates win over a bus write in the same cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      stroke <= ahl_pkg::STROKE_RST;
      limit_in <= ahl_pkg::LIMIT_IN_RST;
      limit_out <= ahl_pkg::LIMIT_OUT_RST;
      range_scale <= ahl_pkg::RANGE_SCALE_RST;
    end else if (at_far_end) begin
      stroke <= position;
      limit_in <= ahl_pkg::SAFE_ZONE_STEPS;
      limit_out <= position - ahl_pkg::SAFE_ZONE_STEPS;
      range_scale <= ahl_pkg::RANGE_SCALE_RST;
    end else begin
      if (cap_out) begin
        limit_out <= position;
      end else if (bus_wr && address == ahl_pkg::OFS_LIMIT_OUT) begin
        limit_out <= writedata[15:0];
      end
      if (cap_in) begin
        limit_in <= position;
      end else if (bus_wr && address == ahl_pkg::OFS_LIMIT_IN) begin
        limit_in <= writedata[15:0];
      end
      // Limits are not derived from a written stroke
      if (bus_wr && address == ahl_pkg::OFS_STROKE) begin
        stroke <= writedata[15:0];
      end
      if (bus_wr && address == ahl_pkg::OFS_RANGE_SCALE) begin
        range_scale <= writedata[15:0];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      home_ext <= ahl_pkg::HOME_EXT_RST;
      learn_speed <= ahl_pkg::LEARN_SPEED_RST;
      run_speed <= ahl_pkg::RUN_SPEED_RST;
    end else if (bus_wr) begin
      // Home end may not change mid-cycle: position sense would flip
      if (address == ahl_pkg::OFS_CTRL && idle) begin
        home_ext <= writedata[ahl_pkg::CTRL_HOME_EXT_BIT];
      end
      if (address == ahl_pkg::OFS_LEARN_SPEED) begin
        learn_speed <= writedata[7:0];
      end
      if (address == ahl_pkg::OFS_RUN_SPEED) begin
        run_speed <= writedata[7:0];
      end
    end
  end

  // ****************************************
  // Motor drive
  // ****************************************
  assign up_ext = !home_ext;
  assign ext_blocked = up_ext ? (position >= limit_out)
                              : (position <= limit_in);
  assign ret_blocked = up_ext ? (position <= limit_in)
                              : (position >= limit_out);

  always_comb begin
    next_extend = 1'b0;
    next_retract = 1'b0;
    next_speed = 8'h00;
    case (state)
      ahl_pkg::AHL_IDLE: begin
        // Both held gives neither single press, so it stays stopped
        if (out_only && !ext_blocked) begin
          next_extend = 1'b1;
          next_speed = run_speed;
        end else if (in_only && !ret_blocked) begin
          next_retract = 1'b1;
          next_speed = run_speed;
        end
      end
      ahl_pkg::AHL_SEEK_HOME, ahl_pkg::AHL_RETURN: begin
        next_extend = home_ext;
        next_retract = !home_ext;
        next_speed = learn_speed;
      end
      ahl_pkg::AHL_SEEK_FAR: begin
        next_extend = !home_ext;
        next_retract = home_ext;
        next_speed = learn_speed;
      end
      default: begin
        next_speed = 8'h00;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      motor_extend <= 1'b0;
      motor_retract <= 1'b0;
      motor_speed <= 8'h00;
      sync_position <= ahl_pkg::HOME_POSITION;
      busy <= 1'b0;
    end else begin
      motor_extend <= next_extend;
      motor_retract <= next_retract;
      motor_speed <= next_speed;
      sync_position <= position;
      busy <= !idle;
    end
  end

  // ****************************************
  // Avalon-MM slave
  // ****************************************
  always_comb begin
    rd_value = 32'h0000_0000;
    if (address == ahl_pkg::OFS_CTRL) begin
      rd_value[ahl_pkg::CTRL_HOME_EXT_BIT] = home_ext;
    end else if (address == ahl_pkg::OFS_STATUS) begin
      rd_value[ahl_pkg::STAT_BUSY_BIT] = !idle;
      rd_value[ahl_pkg::STAT_HOMED_BIT] = homed;
      rd_value[ahl_pkg::STAT_LEARNED_BIT] = learned;
      rd_value[ahl_pkg::STAT_ARMED_BIT] = armed;
      rd_value[ahl_pkg::STAT_LEARN_MODE_BIT] = learn_mode;
      rd_value[ahl_pkg::STAT_STATE_LSB +: 4] = state;
    end else if (address == ahl_pkg::OFS_POSITION) begin
      rd_value[15:0] = position;
    end else if (address == ahl_pkg::OFS_STROKE) begin
      rd_value[15:0] = stroke;
    end else if (address == ahl_pkg::OFS_LIMIT_IN) begin
      rd_value[15:0] = limit_in;
    end else if (address == ahl_pkg::OFS_LIMIT_OUT) begin
      rd_value[15:0] = limit_out;
    end else if (address == ahl_pkg::OFS_LEARN_SPEED) begin
      rd_value[7:0] = learn_speed;
    end else if (address == ahl_pkg::OFS_RUN_SPEED) begin
      rd_value[7:0] = run_speed;
    end else if (address == ahl_pkg::OFS_RANGE_SCALE) begin
      rd_value[15:0] = range_scale;
    end
  end

  // One wait cycle per access keeps read data registered
  always_ff @(posedge clock) begin
    if (rst) begin
      waitrequest <= 1'b1;
      readdata <= 32'h0000_0000;
    end else if ((read || write) && waitrequest) begin
      waitrequest <= 1'b0;
      readdata <= read ? rd_value : 32'h0000_0000;
    end else begin
      waitrequest <= 1'b1;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  a_pos_counts_up: assert property (
    @(posedge clock) disable iff (rst)
    (pulse_edge && motor_extend && !home_ext && !at_home_end)
    |=> position == $past(position) + 16'h0001)
    else $error("position did not count a pulse");
  a_home_zero: assert property (@(posedge clock) disable iff (rst)
    at_home_end |=> position == 16'h0000 && homed)
    else $error("home end did not zero position");
  a_stroke_record: assert property (
    @(posedge clock) disable iff (rst)
    at_far_end |=> stroke == $past(position) && learned &&
                   state == ahl_pkg::AHL_RETURN)
    else $error("far end not recorded");
  a_long_hold: assert property (@(posedge clock) disable iff (rst)
    (learn_go && idle) |=> state == ahl_pkg::AHL_SEEK_HOME && learn_mode)
    else $error("long hold did not start learn");
  a_home_dir: assert property (@(posedge clock) disable iff (rst)
    (state == ahl_pkg::AHL_SEEK_HOME)
    |=> motor_extend == $past(home_ext) && motor_retract != $past(home_ext))
    else $error("homing drives the wrong way");
  a_learn_speed: assert property (
    @(posedge clock) disable iff (rst)
    !idle |=> motor_speed == $past(learn_speed))
    else $error("cycle speed not from learn setting");
  a_scale_reset: assert property (
    @(posedge clock) disable iff (rst)
    at_far_end |=> range_scale == 16'h0400)
    else $error("range scale not restored");
  a_learn_rest: assert property (
    @(posedge clock) disable iff (rst)
    (end_edge && state == ahl_pkg::AHL_RETURN)
    |=> idle ##1 !motor_extend && !motor_retract)
    else $error("learn did not stop at home end");
  a_cap_out: assert property (@(posedge clock) disable iff (rst)
    (cap_out && !at_far_end) |=> limit_out == $past(position) && !armed)
    else $error("outer limit not captured");
  a_cap_in: assert property (@(posedge clock) disable iff (rst)
    (cap_in && !at_far_end) |=> limit_in == $past(position) && !armed)
    else $error("inner limit not captured");
  a_learn_limits: assert property (
    @(posedge clock) disable iff (rst)
    at_far_end |=> limit_in == 16'h0032 &&
                   limit_out == $past(position) - 16'h0032)
    else $error("learned limits wrong");
  a_hold_stopped: assert property (
    @(posedge clock) disable iff (rst)
    (both_held && idle) [*2] |=> !motor_extend && !motor_retract)
    else $error("motor moved while both held");
endmodule // ahl_sequencer

// ==== verif/ahl_motor_model.sv ====
`timescale 1ns/1ps
// ****************************************
// Handset buttons and a motor with a pulse sensor
// ****************************************
module ahl_motor_model #(
  parameter int FULL = 120,
  parameter int START = 30
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic motor_extend,
  input wire logic motor_retract,
  input wire logic press_in,
  input wire logic press_out,
  output logic dir_in_n,
  output logic dir_out_n,
  output logic pulse_pin,
  output logic end_hit,
  output int mpos
);
  logic [2:0] ph;
  logic [3:0] stall;
  logic at_end;
  logic moving;
  assign at_end = (motor_extend && mpos == FULL) ||
                  (motor_retract && mpos == 0);
  assign moving = (motor_extend || motor_retract) && !at_end;
  // Pull-ups hold released buttons high
  always_ff @(posedge clock) begin
    dir_in_n <= !press_in;
    dir_out_n <= !press_out;
  end
  // One step per pulse; the step lands on the rising edge of the pulse
  always_ff @(posedge clock) begin
    if (rst) begin
      mpos <= START;
      ph <= 3'h0;
      pulse_pin <= 1'b0;
    end else if (moving) begin
      ph <= ph + 3'h1;
      if (ph == 3'h7) begin
        pulse_pin <= 1'b1;
        mpos <= mpos + (motor_extend ? 1 : -1);
      end
      if (ph == 3'h3) begin
        pulse_pin <= 1'b0;
      end
    end else begin
      pulse_pin <= 1'b0;
    end
  end
  // Stall is only reported after a delay, as a real current sense would
  always_ff @(posedge clock) begin
    if (rst || !at_end) begin
      stall <= 4'h0;
      end_hit <= 1'b0;
    end else begin
      if (stall != 4'hF) begin
        stall <= stall + 4'h1;
      end
      end_hit <= (stall >= 4'h8);
    end
  end
endmodule // ahl_motor_model

// ==== verif/tb.sv ====
`timescale 1ns/1ps
module tb;
  localparam int FULL = 120;
  logic clock = 0;
  logic rst = 1;
  logic read = 0;
  logic write = 0;
  logic press_in = 0;
  logic press_out = 0;
  logic [5:0] address = 6'h00;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic [31:0] rd;
  logic waitrequest, motor_extend, motor_retract, busy;
  logic dir_in_n, dir_out_n, pulse_pin, end_hit;
  logic [7:0] motor_speed;
  logic [15:0] sync_position;
  int err_total = 0;
  int checks_done = 0;
  int cyc = 0;
  int mpos;
  logic [5:0] ra [10] = '{6'h00, 6'h04, 6'h08, 6'h0C, 6'h10, 6'h14,
                          6'h18, 6'h1C, 6'h20, 6'h24};
  logic [31:0] rv [10] = '{32'h0, 32'h100, 32'h0, 32'h0, 32'h0,
                           32'hFFFF, 32'h40, 32'hFF, 32'h400, 32'h0};
  always #2 clock = ~clock;
  ahl_sequencer #(.HOLD_LIMIT_CYC(32'd20), .HOLD_LEARN_CYC(32'd40)) i_dut (
    .clock(clock), .rst(rst), .dir_in_n(dir_in_n), .dir_out_n(dir_out_n),
    .pulse_pin(pulse_pin), .end_hit(end_hit), .address(address),
    .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest),
    .motor_extend(motor_extend), .motor_retract(motor_retract),
    .motor_speed(motor_speed), .sync_position(sync_position), .busy(busy));
  ahl_motor_model #(.FULL(FULL), .START(30)) i_motor (
    .clock(clock), .rst(rst), .motor_extend(motor_extend),
    .motor_retract(motor_retract), .press_in(press_in),
    .press_out(press_out), .dir_in_n(dir_in_n), .dir_out_n(dir_out_n),
    .pulse_pin(pulse_pin), .end_hit(end_hit), .mpos(mpos));
  // ****************************************
  // Shared tasks
  // ****************************************
  task test_done;
    $display("Checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Held until waitrequest is sampled low; the edge gap avoids double drives
  task bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    @(posedge clock);
    address <= a;
    writedata <= d;
    write <= wr;
    read <= !wr;
    do @(posedge clock); while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task rchk(input string what, input logic [5:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask
  task wait_busy(input logic lvl);
    int n;
    n = 0;
    while (busy !== lvl && n < 5000) begin
      @(posedge clock);
      n++;
    end
    chk("busy", {31'h0, lvl}, {31'h0, busy});
  endtask
  // Release just after a pulse so no step is left half counted
  task move_out(input int len);
    press_out <= 1'b1;
    repeat (len) @(posedge clock);
    while (pulse_pin !== 1'b1) @(posedge clock);
    while (pulse_pin !== 1'b0) @(posedge clock);
    press_out <= 1'b0;
    repeat (10) @(posedge clock);
  endtask
  task arm_press(input logic out_side);
    logic [31:0] p;
    press_in <= 1'b1;
    press_out <= 1'b1;
    repeat (30) @(posedge clock);
    chk("motor stopped", 32'h0, {motor_extend, motor_retract});
    press_in <= 1'b0;
    press_out <= 1'b0;
    repeat (4) @(posedge clock);
    bus(1'b0, ahl_pkg::OFS_STATUS, 32'h0);
    chk("armed", 32'h1, {31'h0, rd[ahl_pkg::STAT_ARMED_BIT]});
    bus(1'b0, ahl_pkg::OFS_POSITION, 32'h0);
    p = rd;
    if (out_side) press_out <= 1'b1;
    else press_in <= 1'b1;
    repeat (4) @(posedge clock);
    press_in <= 1'b0;
    press_out <= 1'b0;
    repeat (6) @(posedge clock);
    rchk("captured limit", out_side ? ahl_pkg::OFS_LIMIT_OUT :
         ahl_pkg::OFS_LIMIT_IN, p);
  endtask
  // ****************************************
  // Timeout
  // ****************************************
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      test_done;
    end
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    for (int i = 0; i < 10; i++) begin
      rchk("reset value", ra[i], rv[i]);
    end
    bus(1'b1, ahl_pkg::OFS_RANGE_SCALE, 32'h123);
    bus(1'b1, ahl_pkg::OFS_LEARN_SPEED, 32'h22);
    bus(1'b1, ahl_pkg::OFS_CTRL, 32'h2);
    wait_busy(1'b1);
    repeat (4) @(posedge clock);
    chk("learn speed", 32'h22, {24'h0, motor_speed});
    chk("seek home", 32'h1, {31'h0, motor_retract});
    wait_busy(1'b0);
    rchk("stroke", ahl_pkg::OFS_STROKE, FULL);
    rchk("inner limit", ahl_pkg::OFS_LIMIT_IN, 32'd50);
    rchk("outer limit", ahl_pkg::OFS_LIMIT_OUT, FULL - 50);
    rchk("range scale", ahl_pkg::OFS_RANGE_SCALE, 32'h400);
    rchk("position", ahl_pkg::OFS_POSITION, 32'h0);
    chk("rest end", 32'h0, mpos);
    bus(1'b0, ahl_pkg::OFS_STATUS, 32'h0);
    chk("homed learned", 32'h3, {30'h0, rd[2:1]});
    move_out(100);
    rchk("position", ahl_pkg::OFS_POSITION, mpos);
    chk("sync position", mpos, {16'h0, sync_position});
    arm_press(1'b0);
    arm_press(1'b1);
    press_in <= 1'b1;
    press_out <= 1'b1;
    repeat (38) @(posedge clock);
    chk("motor stopped", 32'h0, {motor_extend, motor_retract});
    wait_busy(1'b1);
    press_in <= 1'b0;
    press_out <= 1'b0;
    repeat (4) @(posedge clock);
    chk("reduced speed", 32'h22, {24'h0, motor_speed});
    wait_busy(1'b0);
    rchk("stroke", ahl_pkg::OFS_STROKE, FULL);
    bus(1'b1, ahl_pkg::OFS_CTRL, 32'h4);
    bus(1'b1, ahl_pkg::OFS_CTRL, 32'h5);
    wait_busy(1'b1);
    repeat (4) @(posedge clock);
    chk("seek extended", 32'h1, {31'h0, motor_extend});
    wait_busy(1'b0);
    chk("home end", FULL, mpos);
    rchk("position", ahl_pkg::OFS_POSITION, 32'h0);
    rchk("control", ahl_pkg::OFS_CTRL, 32'h4);
    // Read-only place must ignore a write
    bus(1'b1, ahl_pkg::OFS_POSITION, 32'h55);
    rchk("position", ahl_pkg::OFS_POSITION, 32'h0);
    bus(1'b1, ahl_pkg::OFS_STROKE, 32'd100);
    bus(1'b1, ahl_pkg::OFS_LIMIT_IN, 32'd10);
    bus(1'b1, ahl_pkg::OFS_LIMIT_OUT, 32'd90);
    rchk("stroke", ahl_pkg::OFS_STROKE, 32'd100);
    rchk("inner limit", ahl_pkg::OFS_LIMIT_IN, 32'd10);
    rchk("outer limit", ahl_pkg::OFS_LIMIT_OUT, 32'd90);
    test_done;
  end
endmodule // tb
